// ---- include/wsc_pkg.sv ----
// ==========================================================
// Watchdog and sleep/wake control constants
// ==========================================================
// Holds offsets, field positions, reset values and modes.
// Assumes one 25 MHz core-side clock and a plain register port.
//
// How it works
// R1 - Watchdog counts ticks of its own free-running RC oscillator.
// R2 - Time-out while running requests a full device reset.
// R3 - Time-out while asleep wakes the device, no reset.
// R4 - Every time-out clears the time-out flag.
// R5 - Watchdog runs if config enable or soft enable is set.
// R6 - Option register assigns prescaler and selects its ratio.
// R7 - Clear or sleep resets counter, and prescaler when assigned.
// R8 - Clear zeroes prescaler count, assignment bit stays unchanged.
// R9 - Sleep clears watchdog, clears power-down, sets time-out, stops oscillator.
// R10 - During sleep every pin keeps its prior drive state.
// R11 - Reset pin, time-out or enabled interrupt ends sleep; only pin resets.
// R12 - Power-down flag set at power-up, cleared by sleep.
// R13 - In sleep only clockless sources may wake the device.
// R14 - Sleep execution prefetches the next instruction.
// R15 - Interrupt wakes on its own enable, regardless of global enable.
// R16 - After wake run next instruction, then vector if global enable.
// R17 - Pending enabled interrupt makes sleep a no-operation.
// R18 - Interrupt during sleep execution: sleep completes, then wakes at once.
// R19 - Software places no-op after sleep and clears watchdog first.
// R20 - Interrupt flags set regardless of enable bits.
// R21 - Global enable is bit 7 of irq control, cleared by reset.
// R22 - Watchdog clear also sets time-out and power-down flags.
package wsc_pkg;
  // ========================================================
  // Widths
  // ========================================================
  localparam int ADDR_W    = 14;
  localparam int DATA_W    = 8;
  localparam int NUM_SRC   = 7;
  localparam int IO_W      = 8;
  localparam int WDT_CNT_W = 8;
  localparam int PRE_CNT_W = 8;
  // ========================================================
  // Register offsets
  // ========================================================
  localparam logic [13:0] OFS_STATUS   = 14'h0003;
  localparam logic [13:0] OFS_IRQ_CTRL = 14'h000B;
  localparam logic [13:0] OFS_IRQ_FLAG = 14'h000C;
  localparam logic [13:0] OFS_OPTION   = 14'h0081;
  localparam logic [13:0] OFS_POWER_CONTROL_STATUS     = 14'h008E;
  localparam logic [13:0] OFS_CONFIG   = 14'h2007;
  // ========================================================
  // Field positions
  // ========================================================
  localparam int STAT_TO_BIT  = 4;
  localparam int STAT_PD_BIT  = 3;
  localparam int OPT_PSA_BIT  = 3;
  localparam int OPT_PS_MSB   = 2;
  localparam int POWER_CONTROL_STATUS_SEN_BIT = 4;
  localparam int CFG_WEN_BIT  = 3;
  localparam int IRQ_GIE_BIT  = 7;
  // ========================================================
  // Reset values
  // ========================================================
  localparam logic [7:0] OPTION_RST   = 8'hFF;
  localparam logic [7:0] IRQ_CTRL_RST = 8'h00;
  localparam logic       SOFT_EN_RST  = 1'b0;
  // Sources 0..5 need no clock; source 6 is clocked
  localparam logic [6:0] SLEEP_WAKE_MASK = 7'h3F;
  typedef enum logic {WSC_RUN, WSC_SLEEP} wsc_mode_t;
endpackage

// ---- src/wsc_top.sv ----
// ==========================================================
// Watchdog and sleep/wake control
// ==========================================================
// Watchdog, prescaler, status flags and sleep sequencing.
// Assumes the core gives one-cycle execute pulses on i_clk,
// and the RC oscillator arrives as a free-running square wave.
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
module wsc_top (
  input  wire logic        i_clk,
  input  wire logic        i_reset_n,
  input  wire logic [13:0] i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [7:0]  o_rdata,
  input  wire logic        i_rc_osc,
  input  wire logic        i_cfg_wdt_en,
  input  wire logic        i_master_clear_n,
  input  wire logic        i_clr_exec,
  input  wire logic        i_sleep_exec,
  input  wire logic [6:0]  i_irq_event,
  input  wire logic [7:0]  i_io_out,
  input  wire logic [7:0]  i_io_oe_n,
  output logic      [7:0]  o_io_out,
  output logic      [7:0]  o_io_oe_n,
  output logic             o_device_reset,
  output logic             o_sleeping,
  output logic             o_osc_drive_off,
  output logic             o_wake,
  output logic             o_wake_vector,
  output logic             o_sleep_nop,
  output logic             o_prefetch_next,
  output logic             o_irq_take
);
  // ========================================================
  // Input synchronisers
  // ========================================================
  logic [2:0] osc_sync_reg;
  logic [1:0] master_clear_pin_sync_reg;
  logic [1:0] cfg_sync_reg;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      osc_sync_reg  <= 3'h0;
      master_clear_pin_sync_reg <= 2'h3;
      cfg_sync_reg  <= 2'h0;
    end else begin
      osc_sync_reg  <= {osc_sync_reg[1:0], i_rc_osc};
      master_clear_pin_sync_reg <= {master_clear_pin_sync_reg[0], i_master_clear_n};
      cfg_sync_reg  <= {cfg_sync_reg[0], i_cfg_wdt_en};
    end
  end
  // RC edge seen only past the second stage
  logic osc_tick;
  logic master_clear_pin_hit;
  logic cfg_en;
  assign osc_tick = osc_sync_reg[1] & ~osc_sync_reg[2]; // see R1
  assign master_clear_pin_hit = ~master_clear_pin_sync_reg[1];
  assign cfg_en   = cfg_sync_reg[1];

  // ========================================================
  // Registers
  // ========================================================
  logic [7:0] option_reg;
  logic       soft_en_reg;
  logic [7:0] irq_ctrl_reg;
  logic [6:0] irq_flag_reg;
  logic       to_flag_reg;
  logic       pd_flag_reg;
  wsc_pkg::wsc_mode_t mode_reg;
  logic [7:0] pre_cnt_reg;
  logic [7:0] wdt_cnt_reg;
  logic       wdt_rst_reg;

  logic       wr_option;
  logic       wr_power_control_status;
  logic       wr_irq_ctrl;
  logic       wr_irq_flag;
  logic       prescaler_assign_select;
  logic [2:0] ps_rate;
  logic       global_irq_enable;
  logic [6:0] irq_en;
  logic       wdt_run;
  logic       any_reset;
  assign wr_option   = i_wr && i_addr == wsc_pkg::OFS_OPTION;
  assign wr_power_control_status     = i_wr && i_addr == wsc_pkg::OFS_POWER_CONTROL_STATUS;
  assign wr_irq_ctrl = i_wr && i_addr == wsc_pkg::OFS_IRQ_CTRL;
  assign wr_irq_flag = i_wr && i_addr == wsc_pkg::OFS_IRQ_FLAG;
  assign prescaler_assign_select     = option_reg[wsc_pkg::OPT_PSA_BIT]; // see R6
  assign ps_rate = option_reg[wsc_pkg::OPT_PS_MSB:0]; // see R6
  assign global_irq_enable     = irq_ctrl_reg[wsc_pkg::IRQ_GIE_BIT];
  assign irq_en  = irq_ctrl_reg[6:0];
  assign wdt_run = cfg_en | soft_en_reg; // see R5
  assign any_reset = master_clear_pin_hit | wdt_rst_reg;

  // ========================================================
  // Sleep decisions
  // ========================================================
  logic [6:0] live;
  logic       awake_pend;
  logic       sleep_pend;
  logic       sleep_nop;
  logic       sleep_go;
  logic       wdt_timeout;
  logic       wake_wdt;
  logic       wake_irq;
  logic       wake;
  assign live       = irq_flag_reg & irq_en; // see R15
  assign awake_pend = |live;
  assign sleep_pend = |(live & wsc_pkg::SLEEP_WAKE_MASK); // see R13
  assign sleep_nop  = i_sleep_exec && mode_reg == wsc_pkg::WSC_RUN
                      && awake_pend && !any_reset; // see R17
  assign sleep_go   = i_sleep_exec && mode_reg == wsc_pkg::WSC_RUN
                      && !awake_pend && !any_reset;
  assign wake_wdt   = mode_reg == wsc_pkg::WSC_SLEEP && wdt_timeout; // see R3
  assign wake_irq   = mode_reg == wsc_pkg::WSC_SLEEP && sleep_pend; // see R18
  assign wake       = (wake_wdt | wake_irq) && !master_clear_pin_hit; // see R11

  // ========================================================
  // Prescaler and watchdog counter
  // ========================================================
  // Mask of low prescaler bits that must all be one to pass a tick
  function automatic logic [7:0] rate_mask(input logic [2:0] r);
    rate_mask = 8'((9'h001 << r) - 9'h001);
  endfunction

  logic wdt_clr;
  logic wdt_step;
  logic pre_done;
  assign wdt_clr  = i_clr_exec | sleep_go | any_reset | !wdt_run; // see R7
  assign pre_done = (pre_cnt_reg & rate_mask(ps_rate)) == rate_mask(ps_rate);
  assign wdt_step = wdt_run && osc_tick && (!prescaler_assign_select || pre_done); // see R6
  assign wdt_timeout = wdt_step && !wdt_clr && wdt_cnt_reg == 8'hFF;

  // Prescaler cleared only when owned; assignment bit untouched
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pre_cnt_reg <= 8'h00;
    end else if (prescaler_assign_select && wdt_clr) begin
      pre_cnt_reg <= 8'h00; // see R8
    end else if (prescaler_assign_select && osc_tick) begin
      pre_cnt_reg <= pre_done ? 8'h00 : 8'(pre_cnt_reg + 8'h01);
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wdt_cnt_reg <= 8'h00;
    end else if (wdt_clr) begin
      wdt_cnt_reg <= 8'h00; // see R7
    end else if (wdt_step) begin
      wdt_cnt_reg <= 8'(wdt_cnt_reg + 8'h01); // see R1
    end
  end

  // Reset request only when not asleep
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wdt_rst_reg <= 1'b0;
    end else begin
      wdt_rst_reg <= wdt_timeout && mode_reg == wsc_pkg::WSC_RUN; // see R2
    end
  end

  // ========================================================
  // Mode
  // ========================================================
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_reg <= wsc_pkg::WSC_RUN;
    end else begin
      unique case (mode_reg)
        wsc_pkg::WSC_RUN: begin
          if (sleep_go) begin
            mode_reg <= wsc_pkg::WSC_SLEEP; // see R9
          end
        end
        wsc_pkg::WSC_SLEEP: begin
          if (master_clear_pin_hit || wake) begin
            mode_reg <= wsc_pkg::WSC_RUN; // see R11
          end
        end
      endcase
    end
  end

  // ========================================================
  // Status flags
  // ========================================================
  // A same-cycle clear or sleep masks the time-out event, so the flag is set
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      to_flag_reg <= 1'b1;
    end else if (wdt_timeout) begin
      to_flag_reg <= 1'b0; // see R4
    end else if (i_clr_exec || sleep_go) begin
      to_flag_reg <= 1'b1; // see R9 see R22
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pd_flag_reg <= 1'b1; // see R12
    end else if (sleep_go) begin
      pd_flag_reg <= 1'b0; // see R12
    end else if (i_clr_exec) begin
      pd_flag_reg <= 1'b1; // see R22
    end
  end

  // ========================================================
  // Software registers
  // ========================================================
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      option_reg <= wsc_pkg::OPTION_RST;
    end else if (any_reset) begin
      option_reg <= wsc_pkg::OPTION_RST;
    end else if (wr_option) begin
      option_reg <= i_wdata;
    end
  end

  // Soft enable survives pin and watchdog resets
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      soft_en_reg <= wsc_pkg::SOFT_EN_RST;
    end else if (wr_power_control_status) begin
      soft_en_reg <= i_wdata[wsc_pkg::POWER_CONTROL_STATUS_SEN_BIT]; // see R5
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_ctrl_reg <= wsc_pkg::IRQ_CTRL_RST;
    end else if (any_reset) begin
      irq_ctrl_reg <= wsc_pkg::IRQ_CTRL_RST; // see R21
    end else if (wr_irq_ctrl) begin
      irq_ctrl_reg <= i_wdata;
    end
  end

  // Write one to clear; a new event wins over the clear
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      irq_flag_reg <= 7'h00;
    end else begin
      irq_flag_reg <= i_irq_event
        | (irq_flag_reg & ~(wr_irq_flag ? i_wdata[6:0] : 7'h00)); // see R20
    end
  end

  // ========================================================
  // Read port
  // ========================================================
  logic [7:0] rd_val;
  always_comb begin
    rd_val = 8'h00;
    unique case (i_addr)
      wsc_pkg::OFS_STATUS: begin
        rd_val[wsc_pkg::STAT_TO_BIT] = to_flag_reg;
        rd_val[wsc_pkg::STAT_PD_BIT] = pd_flag_reg;
      end
      wsc_pkg::OFS_IRQ_CTRL: rd_val = irq_ctrl_reg;
      wsc_pkg::OFS_IRQ_FLAG: rd_val = {1'b0, irq_flag_reg};
      wsc_pkg::OFS_OPTION:   rd_val = option_reg;
      wsc_pkg::OFS_POWER_CONTROL_STATUS:     rd_val[wsc_pkg::POWER_CONTROL_STATUS_SEN_BIT] = soft_en_reg;
      wsc_pkg::OFS_CONFIG:   rd_val[wsc_pkg::CFG_WEN_BIT] = cfg_en;
      default:               rd_val = 8'h00;
    endcase
  end

  // Data stands only in the cycle after the strobe
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= i_rd ? rd_val : 8'h00;
    end
  end

  // ========================================================
  // Pin hold
  // ========================================================
  // Capture on entry so the core may stop while pins stay put
  genvar g;
  generate
    for (g = 0; g < wsc_pkg::IO_W; g++) begin : g_hold
      always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          o_io_out[g]  <= 1'b0;
          o_io_oe_n[g] <= 1'b1;
        end else if (mode_reg == wsc_pkg::WSC_RUN) begin
          o_io_out[g]  <= i_io_out[g]; // see R10
          o_io_oe_n[g] <= i_io_oe_n[g]; // see R10
        end
      end
    end
  endgenerate

  // ========================================================
  // Core-facing outputs
  // ========================================================
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_wake        <= 1'b0;
      o_wake_vector <= 1'b0;
      o_sleep_nop   <= 1'b0;
    end else begin
      o_wake        <= wake; // see R11
      o_wake_vector <= wake_irq && !master_clear_pin_hit && global_irq_enable; // see R16
      o_sleep_nop   <= sleep_nop; // see R17
    end
  end

  assign o_device_reset  = any_reset; // see R2 see R11
  assign o_sleeping      = mode_reg == wsc_pkg::WSC_SLEEP;
  assign o_osc_drive_off = mode_reg == wsc_pkg::WSC_SLEEP; // see R9
  assign o_prefetch_next = i_sleep_exec && mode_reg == wsc_pkg::WSC_RUN; // see R14
  assign o_irq_take = global_irq_enable && awake_pend && mode_reg == wsc_pkg::WSC_RUN;

  // ========================================================
  // Checks
  // ========================================================
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);

  chk_sleep_flags: assert property ( // see R9
    sleep_go && !wdt_timeout |=> !pd_flag_reg && to_flag_reg && o_sleeping)
    else $error("sleep entry flags wrong");
  chk_timeout_to: assert property ( // see R4
    wdt_timeout |=> !to_flag_reg)
    else $error("time-out left flag set");
  chk_run_reset: assert property ( // see R2
    wdt_timeout && !o_sleeping |=> o_device_reset ##1 !o_sleeping)
    else $error("no reset on time-out");
  chk_sleep_wake: assert property ( // see R3
    wake_wdt && !master_clear_pin_hit |=> o_wake && !o_sleeping && !wdt_rst_reg)
    else $error("time-out in sleep did not wake");
  chk_nop_keeps: assert property ( // see R17
    sleep_nop && !i_clr_exec && !wdt_timeout
    |=> $stable(pd_flag_reg) && $stable(to_flag_reg) && !o_sleeping)
    else $error("sleep nop changed state");
  chk_clr_counter: assert property ( // see R7
    i_clr_exec |=> wdt_cnt_reg == 8'h00 && (!$past(prescaler_assign_select) || pre_cnt_reg == 8'h00))
    else $error("clear left counts");
  chk_clr_psa: assert property ( // see R8
    i_clr_exec && !any_reset && !wr_option |=> $stable(option_reg))
    else $error("clear touched assignment");
  chk_clr_flags: assert property ( // see R22
    i_clr_exec && !sleep_go && !wdt_timeout |=> to_flag_reg && pd_flag_reg)
    else $error("clear did not set flags");
  chk_hold_pins: assert property ( // see R10
    o_sleeping && $past(o_sleeping) |-> $stable(o_io_out) && $stable(o_io_oe_n))
    else $error("pins moved in sleep");
  chk_clocked_no_wake: assert property ( // see R13
    o_sleeping && !(|(live & wsc_pkg::SLEEP_WAKE_MASK)) && !wdt_timeout
    && !master_clear_pin_hit |=> o_sleeping)
    else $error("clocked source woke");
  chk_gie_reset: assert property ( // see R21
    any_reset |=> !global_irq_enable)
    else $error("global enable kept on reset");
  chk_disabled_idle: assert property ( // see R5
    !cfg_en && !soft_en_reg |=> wdt_cnt_reg == 8'h00)
    else $error("watchdog ran disabled");

  cov_wdt_wake:   cover property (wake_wdt ##1 o_wake);
  cov_irq_vector: cover property (sleep_go ##[1:50] o_wake_vector);
  cov_sleep_nop:  cover property (o_sleep_nop);
  cov_run_reset:  cover property (wdt_rst_reg);
endmodule // wsc_top

// ---- tb/tb_top.sv ----
// Self-checking bench for the watchdog and sleep/wake block.
// Assumes a 25 MHz clock and the core model beside the design.
`timescale 1ns/1ps
module tb_top;
  logic        clk;
  logic        reset_n;
  logic [13:0] addr;
  logic [7:0]  wdata;
  logic        wr;
  logic        rd;
  logic        cfg;
  logic        master_clear_pin_n;
  logic        clr;
  logic        slp;
  logic [6:0]  ev;
  logic        rc;
  logic [7:0]  p_out;
  logic [7:0]  p_oe_n;
  logic [7:0]  rdata;
  logic [7:0]  io_out;
  logic [7:0]  io_oe_n;
  logic        dev_rst;
  logic        sleeping;
  logic        osc_off;
  logic        wake;
  logic        wvec;
  logic        snop;
  logic        pref;
  logic        global_irq_enable;
  logic        itake;
  logic        bad;
  logic [7:0]  hold;
  logic [7:0]  hold_oe;
  int          s;
  int          err_total;
  int          cmp_count;

  wsc_core_model core (.i_clk(clk), .o_rc_osc(rc), .o_io_out(p_out), .o_io_oe_n(p_oe_n));

  wsc_top dut (
    .i_clk(clk), .i_reset_n(reset_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_rc_osc(rc),
    .i_cfg_wdt_en(cfg), .i_master_clear_n(master_clear_pin_n), .i_clr_exec(clr),
    .i_sleep_exec(slp), .i_irq_event(ev), .i_io_out(p_out), .i_io_oe_n(p_oe_n),
    .o_io_out(io_out), .o_io_oe_n(io_oe_n), .o_device_reset(dev_rst),
    .o_sleeping(sleeping), .o_osc_drive_off(osc_off), .o_wake(wake),
    .o_wake_vector(wvec), .o_sleep_nop(snop), .o_prefetch_next(pref), .o_irq_take(itake)
  );

  always #20 clk = ~clk;

  // ========================================================
  // Tasks
  // ========================================================
  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: %s", $time, m);
    end
  endtask

  task automatic wrr(input logic [13:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  task automatic rdc(input logic [13:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1 chk(rdata & m, e, "register read");
  endtask

  // Execute pulses and interrupt events share one cycle
  task automatic ex(input logic c, input logic sl, input logic [6:0] e);
    @(posedge clk);
    clr <= c;
    slp <= sl;
    ev  <= e;
    #1 if (sl && !sleeping) chk({7'h00, pref}, 8'h01, "prefetch");
    @(posedge clk);
    clr <= 1'b0;
    slp <= 1'b0;
    ev  <= 7'h00;
    #1;
  endtask

  // Bounded wait: sel 0 waits for wake, 1 for device reset
  task automatic wait_on(input int sel, input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge clk);
      #1;
      if (((sel == 0) ? wake : dev_rst) === 1'b1) return;
    end
    err_total++;
    $display("unexpected at %0t: wait expired", $time);
    give_verdict();
  endtask

  // ========================================================
  // Sequence
  // ========================================================
  initial begin
    clk     = 1'b0;
    reset_n = 1'b0;
    addr    = 14'h0000;
    wdata   = 8'h00;
    wr      = 1'b0;
    rd      = 1'b0;
    cfg     = 1'b0;
    master_clear_pin_n  = 1'b1;
    clr     = 1'b0;
    slp     = 1'b0;
    ev      = 7'h00;
    err_total = 0;
    cmp_count = 0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    rdc(wsc_pkg::OFS_STATUS, 8'h18, 8'h18);
    rdc(wsc_pkg::OFS_OPTION, 8'hFF, 8'hFF);
    rdc(wsc_pkg::OFS_IRQ_CTRL, 8'hFF, 8'h00);
    rdc(wsc_pkg::OFS_POWER_CONTROL_STATUS, 8'h10, 8'h00);
    rdc(14'h0050, 8'hFF, 8'h00);
    wrr(wsc_pkg::OFS_OPTION, 8'h0A);
    rdc(wsc_pkg::OFS_OPTION, 8'hFF, 8'h0A);
    $display("test reset and registers done");
    // Every clockless source wakes; global enable picks the vector
    for (s = 0; s < 6; s++) begin
      global_irq_enable = s[0];
      wrr(wsc_pkg::OFS_IRQ_CTRL, {global_irq_enable, 7'h40 | (7'h01 << s)});
      wrr(wsc_pkg::OFS_IRQ_FLAG, 8'h7F);
      ex(1'b0, 1'b1, 7'h00);
      chk({6'h00, sleeping, osc_off}, 8'h03, "sleep entry");
      if (s == 0) begin
        hold = io_out;
        hold_oe = io_oe_n;
        repeat (5) @(posedge clk);
        #1 chk(io_out, hold, "pins held");
        chk(io_oe_n, hold_oe, "pin enables held");
        rdc(wsc_pkg::OFS_STATUS, 8'h18, 8'h10);
      end
      ex(1'b0, 1'b0, 7'h40);
      repeat (8) @(posedge clk);
      #1 chk({7'h00, sleeping}, 8'h01, "clocked source");
      rdc(wsc_pkg::OFS_IRQ_FLAG, 8'h40, 8'h40);
      ex(1'b0, 1'b0, 7'h01 << s);
      wait_on(0, 6);
      chk({7'h00, wvec}, {7'h00, global_irq_enable}, "vector");
      chk({7'h00, itake}, {7'h00, global_irq_enable}, "interrupt taken");
      wrr(wsc_pkg::OFS_IRQ_FLAG, 8'h7F);
    end
    $display("test interrupt wake done");
    ex(1'b1, 1'b0, 7'h00);
    rdc(wsc_pkg::OFS_STATUS, 8'h18, 8'h18);
    wrr(wsc_pkg::OFS_IRQ_CTRL, 8'h04);
    ex(1'b0, 1'b0, 7'h04);
    ex(1'b0, 1'b1, 7'h00);
    chk({6'h00, snop, sleeping}, 8'h02, "sleep as no-op");
    rdc(wsc_pkg::OFS_STATUS, 8'h18, 8'h18);
    wrr(wsc_pkg::OFS_IRQ_FLAG, 8'h7F);
    wrr(wsc_pkg::OFS_IRQ_CTRL, 8'h10);
    ex(1'b0, 1'b1, 7'h10);
    chk({7'h00, sleeping}, 8'h01, "sleep completes");
    wait_on(0, 6);
    rdc(wsc_pkg::OFS_STATUS, 8'h18, 8'h10);
    wrr(wsc_pkg::OFS_IRQ_FLAG, 8'h7F);
    wrr(wsc_pkg::OFS_IRQ_CTRL, 8'h00);
    $display("test pending interrupt done");
    wrr(wsc_pkg::OFS_OPTION, 8'h08);
    ex(1'b1, 1'b0, 7'h00);
    rdc(wsc_pkg::OFS_OPTION, 8'hFF, 8'h08);
    wrr(wsc_pkg::OFS_OPTION, 8'h00);
    wrr(wsc_pkg::OFS_POWER_CONTROL_STATUS, 8'h10);
    rdc(wsc_pkg::OFS_POWER_CONTROL_STATUS, 8'h10, 8'h10);
    wait_on(1, 2300);
    rdc(wsc_pkg::OFS_STATUS, 8'h10, 8'h00);
    rdc(wsc_pkg::OFS_OPTION, 8'hFF, 8'hFF);
    // Clearing every 150 cycles keeps a 256 tick count from expiring
    wrr(wsc_pkg::OFS_OPTION, 8'h00);
    bad = 1'b0;
    repeat (20) begin
      ex(1'b1, 1'b0, 7'h00);
      repeat (150) begin
        @(posedge clk);
        #1 if (dev_rst === 1'b1) bad = 1'b1;
      end
    end
    chk({7'h00, bad}, 8'h00, "clear holds off");
    // Rate one doubles the ticks per count, so no reset in 3000 cycles
    wrr(wsc_pkg::OFS_OPTION, 8'h09);
    ex(1'b1, 1'b0, 7'h00);
    bad = 1'b0;
    repeat (3000) begin
      @(posedge clk);
      #1 if (dev_rst === 1'b1) bad = 1'b1;
    end
    chk({7'h00, bad}, 8'h00, "prescaler slows");
    wait_on(1, 1500);
    wrr(wsc_pkg::OFS_OPTION, 8'h00);
    wrr(wsc_pkg::OFS_POWER_CONTROL_STATUS, 8'h00);
    $display("test watchdog run done");
    @(posedge clk);
    cfg <= 1'b1;
    // Config enable passes a two-stage synchroniser first
    repeat (2) @(posedge clk);
    rdc(wsc_pkg::OFS_CONFIG, 8'h08, 8'h08);
    ex(1'b1, 1'b0, 7'h00);
    ex(1'b0, 1'b1, 7'h00);
    wait_on(0, 2300);
    chk({7'h00, dev_rst}, 8'h00, "no reset on wake");
    rdc(wsc_pkg::OFS_STATUS, 8'h18, 8'h00);
    @(posedge clk);
    cfg <= 1'b0;
    $display("test watchdog wake done");
    ex(1'b0, 1'b1, 7'h00);
    @(posedge clk);
    master_clear_pin_n <= 1'b0;
    wait_on(1, 4);
    @(posedge clk);
    master_clear_pin_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1 chk({7'h00, sleeping}, 8'h00, "pin ends sleep");
    rdc(wsc_pkg::OFS_STATUS, 8'h18, 8'h10);
    $display("test pin reset done");
    give_verdict();
  end
endmodule // tb_top

// ---- tb/wsc_core_model.sv ----
// Core-side partner: watchdog RC oscillator and pin drive pattern.
// Assumes the bench drives the execute pulses and the register port.
`timescale 1ns/1ps
module wsc_core_model #(
  parameter int RC_HALF_NS = 163
) (
  input  wire logic       i_clk,
  output logic            o_rc_osc,
  output logic      [7:0] o_io_out,
  output logic      [7:0] o_io_oe_n
);
  // ========================================================
  // Oscillator
  // ========================================================
  // Free running, phase unrelated to i_clk, about 8 clocks a period
  initial begin
    o_rc_osc = 1'b0;
  end
  always #(RC_HALF_NS) o_rc_osc = ~o_rc_osc;
  // ========================================================
  // Pin drive
  // ========================================================
  // Changes every cycle so a frozen copy stands out
  initial begin
    o_io_out  = 8'h00;
    o_io_oe_n = 8'hA5;
  end
  always @(posedge i_clk) begin
    o_io_out  <= o_io_out + 8'h01;
    o_io_oe_n <= ~o_io_oe_n;
  end
endmodule // wsc_core_model
